//--- inc/dht_pkg.sv
// Shared constants and types for the dual half timer
package dht_pkg;
    // ==========================================================
    // Module configuration
    typedef enum logic [1:0] {
        DHT_CFG_32_ONE_SHOT,
        DHT_CFG_32_PERIODIC,
        DHT_CFG_32_RTC,
        DHT_CFG_PAIR
    } dht_cfg_t;

    typedef enum logic [2:0] {
        DHT_HALF_ONE_SHOT,
        DHT_HALF_PERIODIC,
        DHT_HALF_CAP_COUNT,
        DHT_HALF_CAP_TIME,
        DHT_HALF_PWM
    } dht_half_mode_t;

    typedef enum logic [1:0] {
        DHT_EDGE_POS,
        DHT_EDGE_NEG,
        DHT_EDGE_BOTH
    } dht_edge_t;

    // ==========================================================
    // Interrupt source bit positions
    localparam int DHT_INT_W = 7;
    localparam int DHT_INT_A_TIMEOUT = 0;
    localparam int DHT_INT_A_CAP_MATCH = 1;
    localparam int DHT_INT_A_CAP_EVENT = 2;
    localparam int DHT_INT_RTC_MATCH = 3;
    localparam int DHT_INT_B_TIMEOUT = 4;
    localparam int DHT_INT_B_CAP_MATCH = 5;
    localparam int DHT_INT_B_CAP_EVENT = 6;

    // ==========================================================
    // Half select bits of a write
    localparam int DHT_SEL_A = 0;
    localparam int DHT_SEL_B = 1;

    // ==========================================================
    // Values after reset
    localparam logic [15:0] DHT_LOAD_RST = 16'hffff;
    localparam logic [15:0] DHT_MATCH_RST = 16'h0000;
    localparam logic [7:0] DHT_PRE_RST = 8'h00;
    localparam logic [7:0] DHT_PREMATCH_RST = 8'h00;
endpackage

//--- rtl/dht_cap_edge.sv
// Capture pin synchroniser and edge selector for one timer half
`timescale 1ns/1ns
`default_nettype none
module dht_cap_edge (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire dht_pkg::dht_edge_t i_edge_sel,
    output logic o_edge
);
    logic meta;
    logic sync;
    logic prev;
    logic next_edge;

    // ==========================================================
    // Edge detect on synchronised level
    always_comb begin
        case (i_edge_sel)
            dht_pkg::DHT_EDGE_POS: next_edge = sync & ~prev;
            dht_pkg::DHT_EDGE_NEG: next_edge = ~sync & prev;
            dht_pkg::DHT_EDGE_BOTH: next_edge = sync ^ prev;
            default: next_edge = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            o_edge <= 1'b0;
        end else begin
            meta <= i_pin;
            sync <= meta;
            prev <= sync;
            o_edge <= next_edge;
        end
    end
endmodule
`default_nettype wire

//--- rtl/dht_timer.sv
// Dual 16-bit half timer with 32-bit one-shot, periodic and clock modes
// ==========================================================
// Functional notes
// - Clear request drops selected raw interrupt sources
// - Only enabled sources reach interrupt output
// - Seven sources: capture, match, timeout, clock match
// - Status readable raw or masked by enables
// - Load write enters running counter at once
// - Edge count equal to match raises match
// - Match value sets PWM duty cycle
// - Prescaler acts only in 16-bit halves
// - Prescale value is eight bits wide
// - Prescale match extends comparison to 24 bits
// - Prescale match value is eight bits wide
// - Clock run clear holds counter value
// - Clock run set works only in clock mode
// - Load, match, prescales and count read back, capture in capture time mode
// - Writes target half A, B or both
// - 32-bit modes or two independent 16-bit halves
// - Capture edge selectable rising, falling or both
// - PWM output invertible to active low
`timescale 1ns/1ns
`default_nettype none
module dht_timer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire dht_pkg::dht_cfg_t i_cfg,
    input wire dht_pkg::dht_half_mode_t i_mode_a,
    input wire dht_pkg::dht_half_mode_t i_mode_b,
    input wire logic i_enable_a,
    input wire logic i_enable_b,
    input wire logic i_rtc_start,
    input wire logic i_rtc_stop,
    input wire dht_pkg::dht_edge_t i_edge_a,
    input wire dht_pkg::dht_edge_t i_edge_b,
    input wire logic i_pwm_invert_a,
    input wire logic i_pwm_invert_b,
    input wire logic i_cap_pin_a,
    input wire logic i_cap_pin_b,
    input wire logic [1:0] i_wr_sel,
    input wire logic i_wr_load,
    input wire logic i_wr_match,
    input wire logic i_wr_prescale,
    input wire logic i_wr_prematch,
    input wire logic [31:0] i_wr_data,
    input wire logic [dht_pkg::DHT_INT_W-1:0] i_int_enable,
    input wire logic [dht_pkg::DHT_INT_W-1:0] i_int_clear,
    input wire logic i_status_masked,
    input wire logic i_rd_half_b,
    output logic [dht_pkg::DHT_INT_W-1:0] o_int_status,
    output logic o_irq,
    output logic o_rtc_running,
    output logic [31:0] o_rd_load,
    output logic [31:0] o_rd_match,
    output logic [7:0] o_rd_prescale,
    output logic [7:0] o_rd_prematch,
    output logic [31:0] o_rd_value,
    output logic o_pwm_a,
    output logic o_pwm_b
);
    logic [15:0] load [2];
    logic [15:0] match [2];
    logic [7:0] pre [2];
    logic [7:0] prematch [2];
    logic [15:0] cnt [2];
    logic [7:0] pre_cnt [2];
    logic [15:0] cap [2];
    logic [1:0] done;
    logic rtc_run;
    logic [dht_pkg::DHT_INT_W-1:0] raw;
    logic [1:0] pwm_lvl;
    logic [1:0] edge_ev;

    logic [15:0] next_load [2];
    logic [15:0] next_match [2];
    logic [7:0] next_pre [2];
    logic [7:0] next_prematch [2];
    logic [15:0] next_cnt [2];
    logic [7:0] next_pre_cnt [2];
    logic [15:0] next_cap [2];
    logic [1:0] next_done;
    logic next_rtc_run;
    logic [dht_pkg::DHT_INT_W-1:0] next_raw;
    logic [1:0] next_pwm_lvl;
    logic [dht_pkg::DHT_INT_W-1:0] next_status;
    logic [31:0] next_rd_load;
    logic [31:0] next_rd_match;
    logic [7:0] next_rd_prescale;
    logic [7:0] next_rd_prematch;
    logic [31:0] next_rd_value;

    // ==========================================================
    // Capture inputs
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_cap
            dht_cap_edge u_cap (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_pin(g == 0 ? i_cap_pin_a : i_cap_pin_b),
                .i_edge_sel(g == 0 ? i_edge_a : i_edge_b),
                .o_edge(edge_ev[g])
            );
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb begin
        logic is32;
        logic run32;
        logic en;
        logic [31:0] v32;
        logic [23:0] v24;
        logic [23:0] l24;
        logic [23:0] m24;
        dht_pkg::dht_half_mode_t hm;
        logic [dht_pkg::DHT_INT_W-1:0] ev;
        is32 = (i_cfg != dht_pkg::DHT_CFG_PAIR);
        run32 = 1'b0;
        en = 1'b0;
        v32 = {cnt[1], cnt[0]};
        v24 = '0;
        l24 = '0;
        m24 = '0;
        hm = dht_pkg::DHT_HALF_ONE_SHOT;
        ev = '0;
        next_load = load;
        next_match = match;
        next_pre = pre;
        next_prematch = prematch;
        next_cnt = cnt;
        next_pre_cnt = pre_cnt;
        next_cap = cap;
        next_done = done;
        next_pwm_lvl = pwm_lvl;
        next_rtc_run = rtc_run;
        if (i_rtc_stop) begin
            next_rtc_run = 1'b0;
        end else if (i_rtc_start && i_cfg == dht_pkg::DHT_CFG_32_RTC) begin
            next_rtc_run = 1'b1;
        end
        if (is32) begin
            // Counter spans both halves, prescaler ignored
            run32 = i_enable_a && !done[0];
            if (i_cfg == dht_pkg::DHT_CFG_32_RTC) begin
                if (i_enable_a && rtc_run) begin
                    v32 = v32 + 32'h0000_0001;
                    if (v32 == {match[1], match[0]}) begin
                        ev[dht_pkg::DHT_INT_RTC_MATCH] = 1'b1;
                    end
                end
            end else if (run32) begin
                if (v32 == 32'h0000_0000) begin
                    ev[dht_pkg::DHT_INT_A_TIMEOUT] = 1'b1;
                    if (i_cfg == dht_pkg::DHT_CFG_32_PERIODIC) begin
                        v32 = {load[1], load[0]};
                    end else begin
                        next_done[0] = 1'b1;
                    end
                end else begin
                    v32 = v32 - 32'h0000_0001;
                end
            end
            next_cnt[0] = v32[15:0];
            next_cnt[1] = v32[31:16];
            if (!i_enable_a) begin
                next_done[0] = 1'b0;
            end
        end else begin
            for (int h = 0; h < 2; h++) begin
                en = (h == 0) ? i_enable_a : i_enable_b;
                hm = (h == 0) ? i_mode_a : i_mode_b;
                v24 = {pre_cnt[h], cnt[h]};
                l24 = {pre[h], load[h]};
                m24 = {prematch[h], match[h]};
                case (hm)
                    dht_pkg::DHT_HALF_ONE_SHOT, dht_pkg::DHT_HALF_PERIODIC: begin
                        if (en && !done[h]) begin
                            if (pre_cnt[h] != 8'h00) begin
                                v24[23:16] = pre_cnt[h] - 8'h01;
                            end else begin
                                v24[23:16] = pre[h];
                                if (cnt[h] == 16'h0000) begin
                                    ev[h * 4] = 1'b1;
                                    if (hm == dht_pkg::DHT_HALF_PERIODIC) begin
                                        v24[15:0] = load[h];
                                    end else begin
                                        next_done[h] = 1'b1;
                                    end
                                end else begin
                                    v24[15:0] = cnt[h] - 16'h0001;
                                end
                            end
                        end
                    end
                    dht_pkg::DHT_HALF_CAP_COUNT: begin
                        if (en && edge_ev[h]) begin
                            v24 = v24 - 24'h00_0001;
                            if (v24 == m24) begin
                                ev[h * 4 + 1] = 1'b1;
                                v24 = l24;
                            end
                        end
                    end
                    dht_pkg::DHT_HALF_CAP_TIME: begin
                        if (en) begin
                            v24 = (v24 == 24'h00_0000) ? l24 : v24 - 24'h00_0001;
                            if (edge_ev[h]) begin
                                next_cap[h] = cnt[h];
                                ev[h * 4 + 2] = 1'b1;
                            end
                        end
                    end
                    dht_pkg::DHT_HALF_PWM: begin
                        if (en) begin
                            v24 = (v24 == 24'h00_0000) ? l24 : v24 - 24'h00_0001;
                        end
                        next_pwm_lvl[h] = (v24 > m24) ^ ((h == 0) ? i_pwm_invert_a
                            : i_pwm_invert_b);
                    end
                    default: begin
                        v24 = {pre_cnt[h], cnt[h]};
                    end
                endcase
                next_pre_cnt[h] = v24[23:16];
                next_cnt[h] = v24[15:0];
                if (!en) begin
                    next_done[h] = 1'b0;
                end
            end
        end
        // Software writes; in 32-bit mode half A carries all 32 bits
        for (int h = 0; h < 2; h++) begin
            if (is32 ? i_wr_sel[dht_pkg::DHT_SEL_A] : i_wr_sel[h]) begin
                if (i_wr_load) begin
                    next_load[h] = (is32 && h == 1) ? i_wr_data[31:16] : i_wr_data[15:0];
                    next_cnt[h] = next_load[h];
                    next_pre_cnt[h] = pre[h];
                    next_done[h] = 1'b0;
                end
                if (i_wr_match) begin
                    next_match[h] = (is32 && h == 1) ? i_wr_data[31:16] : i_wr_data[15:0];
                end
                if (i_wr_prescale && !is32) begin
                    next_pre[h] = i_wr_data[7:0];
                end
                if (i_wr_prematch && !is32) begin
                    next_prematch[h] = i_wr_data[7:0];
                end
            end
        end
        next_raw = (raw & ~i_int_clear) | ev;
        next_status = i_status_masked ? (next_raw & i_int_enable) : next_raw;
        // Read back of selected half; in 32-bit mode both halves together
        if (is32) begin
            next_rd_load = {next_load[1], next_load[0]};
            next_rd_match = {next_match[1], next_match[0]};
            next_rd_value = {next_cnt[1], next_cnt[0]};
            next_rd_prescale = next_pre[0];
            next_rd_prematch = next_prematch[0];
        end else begin
            next_rd_load = {16'h0000, next_load[i_rd_half_b]};
            next_rd_match = {16'h0000, next_match[i_rd_half_b]};
            next_rd_prescale = next_pre[i_rd_half_b];
            next_rd_prematch = next_prematch[i_rd_half_b];
            hm = i_rd_half_b ? i_mode_b : i_mode_a;
            next_rd_value = (hm == dht_pkg::DHT_HALF_CAP_TIME)
                ? {16'h0000, next_cap[i_rd_half_b]}
                : {16'h0000, next_cnt[i_rd_half_b]};
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int h = 0; h < 2; h++) begin
                load[h] <= dht_pkg::DHT_LOAD_RST;
                match[h] <= dht_pkg::DHT_MATCH_RST;
                pre[h] <= dht_pkg::DHT_PRE_RST;
                prematch[h] <= dht_pkg::DHT_PREMATCH_RST;
                cnt[h] <= dht_pkg::DHT_LOAD_RST;
                pre_cnt[h] <= dht_pkg::DHT_PRE_RST;
                cap[h] <= 16'h0000;
            end
            done <= 2'h0;
            rtc_run <= 1'b0;
            raw <= '0;
            pwm_lvl <= 2'h0;
            o_int_status <= '0;
            o_irq <= 1'b0;
            o_rtc_running <= 1'b0;
            o_rd_load <= 32'h0000_0000;
            o_rd_match <= 32'h0000_0000;
            o_rd_prescale <= 8'h00;
            o_rd_prematch <= 8'h00;
            o_rd_value <= 32'h0000_0000;
            o_pwm_a <= 1'b0;
            o_pwm_b <= 1'b0;
        end else begin
            load <= next_load;
            match <= next_match;
            pre <= next_pre;
            prematch <= next_prematch;
            cnt <= next_cnt;
            pre_cnt <= next_pre_cnt;
            cap <= next_cap;
            done <= next_done;
            rtc_run <= next_rtc_run;
            raw <= next_raw;
            pwm_lvl <= next_pwm_lvl;
            o_int_status <= next_status;
            o_irq <= |(next_raw & i_int_enable);
            o_rtc_running <= next_rtc_run;
            o_rd_load <= next_rd_load;
            o_rd_match <= next_rd_match;
            o_rd_prescale <= next_rd_prescale;
            o_rd_prematch <= next_rd_prematch;
            o_rd_value <= next_rd_value;
            o_pwm_a <= next_pwm_lvl[0];
            o_pwm_b <= next_pwm_lvl[1];
        end
    end
endmodule
`default_nettype wire

//--- test/dht_cap_src.sv
// Capture pin source standing in for the outside world
`timescale 1ns/1ns
`default_nettype none
module dht_cap_src (
    input wire logic i_clk,
    output logic o_pin_a,
    output logic o_pin_b
);
    logic [1:0] pins = 2'b00;
    assign o_pin_a = pins[0];
    assign o_pin_b = pins[1];
    // Each pulse gives one rising and one falling edge, off the clock edge
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            @(posedge i_clk);
            #7 pins[b] = 1'b1;
            repeat (4) @(posedge i_clk);
            #7 pins[b] = 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- test/dht_timer_checker.sv
// Port checker for the dual half timer, with its bind
`timescale 1ns/1ns
`default_nettype none
module dht_timer_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire dht_pkg::dht_cfg_t i_cfg,
    input wire dht_pkg::dht_half_mode_t i_mode_a,
    input wire logic i_rtc_start,
    input wire logic i_rtc_stop,
    input wire logic [1:0] i_wr_sel,
    input wire logic i_wr_load,
    input wire logic i_wr_prescale,
    input wire logic [31:0] i_wr_data,
    input wire logic [dht_pkg::DHT_INT_W-1:0] i_int_enable,
    input wire logic i_status_masked,
    input wire logic i_rd_half_b,
    input wire logic [dht_pkg::DHT_INT_W-1:0] o_int_status,
    input wire logic o_irq,
    input wire logic o_rtc_running,
    input wire logic [31:0] o_rd_load,
    input wire logic [7:0] o_rd_prescale,
    input wire logic [31:0] o_rd_value
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Assertions
    chk_irq_enabled: assert property (
        !$past(i_status_masked) |-> o_irq == |(o_int_status & $past(i_int_enable)))
        else $error("irq differs from enabled raw status");
    chk_masked_view: assert property (
        $past(i_status_masked) |-> (o_int_status & ~$past(i_int_enable)) == 7'h00)
        else $error("masked status shows a disabled source");
    chk_rtc_mode_only: assert property (
        i_rtc_start && i_cfg != dht_pkg::DHT_CFG_32_RTC && !o_rtc_running |=> !o_rtc_running)
        else $error("clock run started outside clock mode");
    chk_rtc_stop: assert property (i_rtc_stop |=> !o_rtc_running)
        else $error("clock run not cleared by stop");
    chk_rtc_hold: assert property (
        i_cfg == dht_pkg::DHT_CFG_32_RTC && i_cfg == $past(i_cfg) && !$past(i_rst)
        && !o_rtc_running && !i_wr_load |=> $stable(o_rd_value))
        else $error("stopped clock counter moved");
    chk_load_readback: assert property (
        i_wr_load && i_wr_sel[0] && i_cfg == dht_pkg::DHT_CFG_PAIR && !i_rd_half_b
        |=> o_rd_load[15:0] == $past(i_wr_data[15:0])) else $error("load readback wrong");
    chk_load_enters: assert property (
        i_wr_load && i_wr_sel[0] && i_cfg == dht_pkg::DHT_CFG_PAIR && !i_rd_half_b
        && i_mode_a inside {dht_pkg::DHT_HALF_ONE_SHOT, dht_pkg::DHT_HALF_PERIODIC}
        |=> o_rd_value[15:0] == $past(i_wr_data[15:0])) else $error("load not in counter");
    chk_prescale_ignored: assert property (
        i_wr_prescale && i_cfg != dht_pkg::DHT_CFG_PAIR && i_cfg == $past(i_cfg)
        && !$past(i_rst) |=> $stable(o_rd_prescale)) else $error("prescale taken in 32-bit");
endmodule
bind dht_timer dht_timer_checker u_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .i_mode_a(i_mode_a),
    .i_rtc_start(i_rtc_start), .i_rtc_stop(i_rtc_stop), .i_wr_sel(i_wr_sel),
    .i_wr_load(i_wr_load), .i_wr_prescale(i_wr_prescale), .i_wr_data(i_wr_data),
    .i_int_enable(i_int_enable), .i_status_masked(i_status_masked),
    .i_rd_half_b(i_rd_half_b), .o_int_status(o_int_status), .o_irq(o_irq),
    .o_rtc_running(o_rtc_running), .o_rd_load(o_rd_load), .o_rd_prescale(o_rd_prescale),
    .o_rd_value(o_rd_value)
);
`default_nettype wire

//--- test/dht_timer_tb.sv
// Self-checking bench for the dual half timer
`timescale 1ns/1ns
`default_nettype none
module dht_timer_tb;
    logic i_clk = 0, i_rst = 1, en_a = 0, en_b = 0, go = 0, halt = 0, inv = 0, msk = 0, rdb = 0;
    dht_pkg::dht_cfg_t cfg = dht_pkg::DHT_CFG_PAIR;
    dht_pkg::dht_half_mode_t mode_a = dht_pkg::DHT_HALF_ONE_SHOT;
    dht_pkg::dht_half_mode_t mode_b = dht_pkg::DHT_HALF_ONE_SHOT;
    dht_pkg::dht_edge_t edge_a = dht_pkg::DHT_EDGE_POS;
    logic [1:0] sel = 0;
    logic [3:0] wr = 0;
    logic [31:0] data = 0, rl, rm, rv, v;
    logic [6:0] ien = 0, iclr = 0, st;
    logic irq, run, pwm_a, pwm_b, pin_a, pin_b;
    logic [7:0] rp, rq;
    logic [15:0] la [2], ma [2];
    logic [7:0] pa [2], qa [2];
    int n_mismatch = 0, comparisons = 0, cyc_n = 0, hi, hb;
    dht_cap_src src (.i_clk(i_clk), .o_pin_a(pin_a), .o_pin_b(pin_b));
    dht_timer DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_mode_a(mode_a), .i_mode_b(mode_b),
        .i_enable_a(en_a), .i_enable_b(en_b), .i_rtc_start(go), .i_rtc_stop(halt),
        .i_edge_a(edge_a), .i_edge_b(edge_a), .i_pwm_invert_a(inv),
        .i_pwm_invert_b(~inv), .i_cap_pin_a(pin_a), .i_cap_pin_b(pin_b), .i_wr_sel(sel),
        .i_wr_load(wr[0]), .i_wr_match(wr[1]), .i_wr_prescale(wr[2]), .i_wr_prematch(wr[3]),
        .i_wr_data(data), .i_int_enable(ien), .i_int_clear(iclr), .i_status_masked(msk),
        .i_rd_half_b(rdb), .o_int_status(st), .o_irq(irq), .o_rtc_running(run),
        .o_rd_load(rl), .o_rd_match(rm), .o_rd_prescale(rp), .o_rd_prematch(rq),
        .o_rd_value(rv), .o_pwm_a(pwm_a), .o_pwm_b(pwm_b)
    );
    always #20 i_clk = ~i_clk;
    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic write(input int k, input logic [1:0] s, input logic [31:0] d);
        sel = s;
        data = d;
        wr[k] = 1'b1;
        tick(1);
        wr = 4'h0;
        tick(1);
    endtask
    task automatic clear(input logic [6:0] m);
        iclr = m;
        tick(1);
        iclr = 7'h00;
        tick(1);
    endtask
    task automatic wait_st(input int b);
        hi = 0;
        while (st[b] !== 1'b1 && hi < 40) begin
            tick(1);
            hi++;
        end
        check(st[b], 1);
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(5));
        tick(5);
        i_rst = 0;
        tick(1);
        la = '{dht_pkg::DHT_LOAD_RST, dht_pkg::DHT_LOAD_RST};
        pa = '{dht_pkg::DHT_PRE_RST, dht_pkg::DHT_PRE_RST};
        ma = '{dht_pkg::DHT_MATCH_RST, dht_pkg::DHT_MATCH_RST};
        qa = '{dht_pkg::DHT_PREMATCH_RST, dht_pkg::DHT_PREMATCH_RST};
        check(rl[15:0], la[0]);
        for (int s = 1; s < 4; s++) begin
            v = $urandom;
            write(0, s[1:0], v);
            write(1, s[1:0], v >> 16);
            write(2, s[1:0], {24'h0, v[7:0]});
            write(3, s[1:0], {24'h0, v[15:8]});
            for (int h = 0; h < 2; h++) begin
                if (s[h]) begin
                    la[h] = v[15:0];
                    ma[h] = v[31:16];
                    pa[h] = v[7:0];
                    qa[h] = v[15:8];
                end
            end
            for (int h = 0; h < 2; h++) begin
                rdb = h[0];
                tick(2);
                check(rl[15:0], la[h]);
                check(rv[15:0], la[h]);
                check(rp, pa[h]);
                check(rm[15:0], ma[h]);
                check(rq, qa[h]);
            end
            rdb = 0;
        end
        cfg = dht_pkg::DHT_CFG_32_ONE_SHOT;
        tick(1);
        write(2, 2'b01, {24'h0, ~pa[0]});
        tick(2);
        check(rp, pa[0]);
        write(0, 2'b01, 32'd20);
        en_a = 1;
        wait_st(0);
        tick(2);
        check(rv, 0);
        check(irq, 0);
        msk = 1;
        tick(2);
        check(st, 0);
        ien = 7'h01;
        tick(2);
        check(st, 7'h01);
        check(irq, 1);
        clear(7'h01);
        check(st, 0);
        check(irq, 0);
        cfg = dht_pkg::DHT_CFG_32_PERIODIC;
        write(0, 2'b01, 32'd9);
        repeat (2) begin
            wait_st(0);
            clear(7'h01);
        end
        ien = 7'h00;
        msk = 1'b0;
        cfg = dht_pkg::DHT_CFG_PAIR;
        go = 1;
        tick(1);
        go = 0;
        tick(1);
        check(run, 0);
        cfg = dht_pkg::DHT_CFG_32_RTC;
        write(0, 2'b01, 0);
        write(1, 2'b01, 32'd5);
        go = 1;
        tick(1);
        go = 0;
        tick(7);
        halt = 1;
        tick(1);
        halt = 0;
        tick(4);
        check(run, 0);
        check(rv, 8);
        check(st[3], 1);
        // Periodic half with prescaler: period is (load+1)*(prescale+1)
        cfg = dht_pkg::DHT_CFG_PAIR;
        mode_a = dht_pkg::DHT_HALF_PERIODIC;
        v = $urandom_range(3);
        write(2, 2'b01, v);
        write(0, 2'b01, 3);
        clear(7'h01);
        wait_st(0);
        clear(7'h01);
        wait_st(0);
        check(hi, 4 * v + 2);
        en_a = 1'b0;
        mode_a = dht_pkg::DHT_HALF_PWM;
        mode_b = dht_pkg::DHT_HALF_PWM;
        write(2, 2'b11, 0);
        write(3, 2'b11, 0);
        v = 1 + $urandom_range(7);
        write(1, 2'b11, v);
        write(0, 2'b11, 9);
        en_a = 1;
        en_b = 1;
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            tick(12);
            hi = 0;
            hb = 0;
            repeat (30) begin
                tick(1);
                hi += pwm_a;
                hb += pwm_b;
            end
            check(hi, 3 * (i ? v + 1 : 9 - v));
            check(hb, 3 * (i ? 9 - v : v + 1));
        end
        mode_a = dht_pkg::DHT_HALF_CAP_COUNT;
        for (int e = 0; e < 3; e++) begin
            edge_a = dht_pkg::dht_edge_t'(e);
            v = 2 * (1 + $urandom_range(2));
            write(1, 2'b01, 10 - v);
            write(0, 2'b01, 10);
            clear(7'h02);
            src.pulse(0, (e == 2 ? v / 2 : v) - 1);
            tick(6);
            check(st[1], 0);
            src.pulse(0, 1);
            tick(6);
            check(st[1], 1);
        end
        // Prescale match differs: low 16 bits alone would match after two edges
        write(3, 2'b01, 1);
        write(1, 2'b01, 8);
        write(0, 2'b01, 10);
        clear(7'h02);
        src.pulse(0, 1);
        tick(6);
        check(st[1], 0);
        mode_b = dht_pkg::DHT_HALF_CAP_TIME;
        en_b = 1'b1;
        clear(7'h40);
        src.pulse(1, 1);
        tick(6);
        check(st[6], 1);
        end_of_test;
    end
endmodule
`default_nettype wire
